// file: hdl/call_stack_mem.sv
// little memory holding the return addresses of the hardware call stack
module call_stack_mem
    import ret_rot_pkg::*;
#(
    parameter int W = PC_W,
    parameter int N = DEPTH,
    parameter int AW = PTR_W
) (
    input wire logic clk,
    input wire logic ce,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [W-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [W-1:0] rdata
);
    logic [W-1:0] mem [N];

    // =========================================================
    // registered read keeps the pop path to the program counter short
    always_ff @(posedge clk) begin
        if (ce) begin
            if (we) begin
                mem[waddr] <= wdata;
            end
            rdata <= mem[raddr];
        end
    end
endmodule : call_stack_mem

// file: hdl/ret_rot_pkg.sv
// package: constants and types for the return and rotate execution block
package ret_rot_pkg;

    // =========================================================
    // constants
    localparam int PC_W = 15;
    localparam int DEPTH = 16;
    localparam int PTR_W = 4;
    localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
    localparam int CARRY_POS = 0;
    localparam logic [7:0] W_RST = 8'h00;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] INTCTL_RST = 8'h00;
    localparam logic [7:0] FWR_RST = 8'h00;
    localparam logic [PC_W-1:0] PC_RST = 15'h0000;
    localparam logic [PTR_W-1:0] SP_RST = 4'hF;

    // =========================================================
    // types
    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_INT_RET = 3'h1,
        OP_SUB_RET = 3'h2,
        OP_LIT_RET = 3'h3,
        OP_ROT_LEFT = 3'h4,
        OP_CALL = 3'h5
    } op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FLUSH = 2'b01
    } state_t;

    typedef struct packed {
        op_t op;
        logic [7:0] lit;
        logic dest;
        logic [7:0] fdata;
        logic [PC_W-1:0] push_addr;
    } instr_t;

    typedef struct packed {
        logic [7:0] w;
        logic [7:0] status;
        logic [7:0] intctl;
        logic [PC_W-1:0] pc;
        logic [7:0] fwr_data;
        logic fwr_en;
        logic busy;
    } result_t;

endpackage : ret_rot_pkg

// file: hdl/return_and_rotate_exec.sv
// core execution of interrupt return, subroutine return, literal return and rotate left
module return_and_rotate_exec
    import ret_rot_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic instr_valid,
    input instr_t instr,
    output logic instr_ready,
    output result_t result
);

    // =========================================================
    // types and reset image
    // flag view of the opcode (an interrupt return sets both pop and irq_on), shared by every consumer
    typedef struct packed {
        logic pop;
        logic irq_on;
        logic lit_load;
        logic rot;
        logic push;
    } dec_t;

    typedef struct packed {
        logic carry;
        logic [7:0] value;
    } rot_t;

    // write and read side of the stack memory travel together
    typedef struct packed {
        logic we;
        logic [PTR_W-1:0] waddr;
        logic [PC_W-1:0] wdata;
        logic [PTR_W-1:0] raddr;
    } stack_port_t;

    // pop_irq_en carries the interrupt flavour of a return into its second cycle
    typedef struct packed {
        state_t st;
        logic [PTR_W-1:0] sp;
        logic [7:0] w;
        logic [7:0] status;
        logic [7:0] intctl;
        logic [PC_W-1:0] pc;
        logic [7:0] fwr_data;
        logic fwr_en;
        logic pop_irq_en;
    } core_t;

    // reset image; the stack memory itself is left uncleared
    localparam core_t CORE_RST = '{
        st: ST_IDLE,
        sp: SP_RST,
        w: W_RST,
        status: STATUS_RST,
        intctl: INTCTL_RST,
        pc: PC_RST,
        fwr_data: FWR_RST,
        fwr_en: 1'b0,
        pop_irq_en: 1'b0
    };

    core_t s_r;
    core_t s_nxt;
    dec_t dec;
    rot_t rot_res;
    stack_port_t stk;
    logic take;
    logic [PC_W-1:0] top_of_call_stack;

    // =========================================================
    // helpers
    // the pointer wraps both ways, so popping an empty stack reads the top slot
    function automatic logic [PTR_W-1:0] sp_step(input logic [PTR_W-1:0] sp, input logic up);
        sp_step = up ? PTR_W'(sp + 1'b1) : PTR_W'(sp - 1'b1);
    endfunction : sp_step

    // one decode serves the stack write port and the next-state logic alike
    function automatic dec_t decode(input op_t op);
        decode = '0;
        unique case (op)
            OP_INT_RET: begin
                decode.pop = 1'b1;
                decode.irq_on = 1'b1;
            end
            OP_SUB_RET: begin
                decode.pop = 1'b1;
            end
            OP_LIT_RET: begin
                decode.pop = 1'b1;
                decode.lit_load = 1'b1;
            end
            OP_ROT_LEFT: begin
                decode.rot = 1'b1;
            end
            OP_CALL: begin
                decode.push = 1'b1;
            end
            default: begin
            end
        endcase
    endfunction : decode

    function automatic rot_t rot_left_carry(input logic [7:0] value, input logic carry_in);
        rot_left_carry.value = {value[6:0], carry_in};
        rot_left_carry.carry = value[7];
    endfunction : rot_left_carry

    // the enable is only ever set here; clearing it belongs to other logic
    function automatic logic [7:0] irq_enable_set(input logic [7:0] ctl);
        irq_enable_set = ctl;
        irq_enable_set[GLOBAL_IRQ_ENABLE_BIT] = 1'b1;
    endfunction : irq_enable_set

    // =========================================================
    // stack storage; top_of_call_stack is the entry at the current pointer
    // ce also gates the memory, so a frozen core keeps its return addresses
    call_stack_mem #(
        .W(PC_W),
        .N(DEPTH),
        .AW(PTR_W)
    ) u_stack (
        .clk(clk),
        .ce(ce),
        .we(stk.we),
        .waddr(stk.waddr),
        .wdata(stk.wdata),
        .raddr(stk.raddr),
        .rdata(top_of_call_stack)
    );

    // =========================================================
    // accept and decode
    assign instr_ready = (s_r.st == ST_IDLE);
    assign take = instr_valid && instr_ready;
    assign dec = decode(instr.op);

    always_comb begin
        stk.we = take && dec.push;
        stk.waddr = sp_step(s_r.sp, 1'b1);
        stk.wdata = instr.push_addr;
        // the read follows the pointer a push is moving to
        stk.raddr = stk.we ? stk.waddr : s_r.sp;
    end

    // =========================================================
    // rotate datapath
    // carry in is the registered flag, so back-to-back rotates chain through it
    assign rot_res = rot_left_carry(instr.fdata, s_r.status[CARRY_POS]);

    // =========================================================
    // next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.fwr_en = 1'b0;
        unique case (s_r.st)
            ST_IDLE: begin
                if (take) begin
                    if (dec.pop) begin
                        // no return touches the status flags
                        s_nxt.pop_irq_en = dec.irq_on;
                        s_nxt.st = ST_FLUSH;
                    end
                    if (dec.lit_load) begin
                        s_nxt.w = instr.lit;
                    end
                    if (dec.rot) begin
                        // only the carry bit of status is written
                        s_nxt.status[CARRY_POS] = rot_res.carry;
                        if (instr.dest) begin
                            s_nxt.fwr_data = rot_res.value;
                            s_nxt.fwr_en = 1'b1;
                        end else begin
                            s_nxt.w = rot_res.value;
                        end
                    end
                    if (dec.push) begin
                        s_nxt.sp = stk.waddr;
                    end
                end
            end
            ST_FLUSH: begin
                // second cycle: the popped entry is out of the registered read now
                s_nxt.pc = top_of_call_stack;
                s_nxt.sp = sp_step(s_r.sp, 1'b0);
                if (s_r.pop_irq_en) begin
                    s_nxt.intctl = irq_enable_set(s_r.intctl);
                end
                s_nxt.pop_irq_en = 1'b0;
                s_nxt.st = ST_IDLE;
            end
            default: begin
                s_nxt.st = ST_IDLE;
            end
        endcase
    end

    // =========================================================
    // state register; ce low holds every field, a pending pop included
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= CORE_RST;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // =========================================================
    // outputs come straight from the state register
    always_comb begin
        result.w = s_r.w;
        result.status = s_r.status;
        result.intctl = s_r.intctl;
        result.pc = s_r.pc;
        result.fwr_data = s_r.fwr_data;
        result.fwr_en = s_r.fwr_en;
        result.busy = (s_r.st != ST_IDLE);
    end

endmodule : return_and_rotate_exec

// file: testbench/ret_rot_properties.sv
// assertion checker for the return and rotate execution block
module ret_rot_properties
    import ret_rot_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic instr_valid,
    input instr_t instr,
    input wire logic instr_ready,
    input result_t result
);
    timeunit 1ns;
    timeprecision 1ns;
    // =========================================================
    // helpers
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic tk = ce && instr_valid && instr_ready;
    sequence s_ret;
        tk && instr.op inside {OP_INT_RET, OP_SUB_RET, OP_LIT_RET};
    endsequence
    sequence s_rot;
        tk && instr.op == OP_ROT_LEFT;
    endsequence
    // =========================================================
    // properties
    AST_RET_BUSY: assert property (s_ret |=> result.busy && !instr_ready)
        else $error("return not held for a second cycle");
    AST_RET_IRQ_EN: assert property (s_ret ##0 instr.op == OP_INT_RET ##1 ce |=>
        result.intctl[GLOBAL_IRQ_ENABLE_BIT])
        else $error("interrupt enable not set");
    AST_RET_FLAGS: assert property (s_ret |-> ##2 result.status == $past(result.status, 2))
        else $error("return changed status");
    AST_SUB_IRQ_EN: assert property (s_ret ##0 instr.op == OP_SUB_RET |-> ##2
        result.intctl == $past(result.intctl, 2))
        else $error("subroutine return changed interrupt control");
    AST_LIT_W: assert property (s_ret ##0 instr.op == OP_LIT_RET |=> result.w == $past(instr.lit))
        else $error("literal not in working register");
    AST_ROT_C: assert property (s_rot |=> result.status == {$past(result.status[7:1]), $past(instr.fdata[7])})
        else $error("rotate carry wrong");
    AST_ROT_FILE: assert property (s_rot ##0 instr.dest |=> result.fwr_en &&
        result.fwr_data == {$past(instr.fdata[6:0]), $past(result.status[0])})
        else $error("rotate file result wrong");
    AST_ROT_W: assert property (s_rot ##0 !instr.dest |=> !result.fwr_en &&
        result.w == {$past(instr.fdata[6:0]), $past(result.status[0])})
        else $error("rotate working result wrong");
endmodule : ret_rot_properties

bind return_and_rotate_exec ret_rot_properties i_props (.clk(clk), .rst_n(rst_n), .ce(ce),
    .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready), .result(result));

// file: testbench/testbench.sv
// self-checking bench for the return and rotate execution block
module testbench
    import ret_rot_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic instr_valid = 1'b0;
    instr_t instr = '0;
    logic instr_ready;
    result_t result;
    int n_mismatch = 0;
    int n_tests = 0;
    always #10 clk = ~clk;
    return_and_rotate_exec i_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .instr_valid(instr_valid),
        .instr(instr), .instr_ready(instr_ready), .result(result));
    // =========================================================
    // shared tasks
    task automatic print_verdict;
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // bounded wait: a stuck ready ends the run as a failure
    task automatic issue(input op_t op, input logic [7:0] lit, input logic dest, input logic [7:0] fd,
        input logic [14:0] pa);
        int i;
        @(negedge clk);
        instr_valid = 1'b1;
        instr = '{op, lit, dest, fd, pa};
        for (i = 0; i < 8 && instr_ready !== 1'b1; i++) @(negedge clk);
        if (i == 8) begin
            n_mismatch++;
            print_verdict();
        end else begin
            @(negedge clk);
            instr_valid = 1'b0;
        end
    endtask : issue
    task automatic ret(input op_t op, input logic [7:0] lit, input logic [14:0] pc);
        issue(op, lit, 1'b0, 8'h00, 15'h0000);
        chk({result.busy, instr_ready}, 2'h2);
        @(negedge clk);
        chk(result.pc, pc);
    endtask : ret
    // =========================================================
    // scenarios
    task automatic sc_int_ret;
        issue(OP_CALL, 8'h00, 1'b0, 8'h00, 15'h7ABC);
        ret(OP_INT_RET, 8'h00, 15'h7ABC);
        chk(result.intctl, 8'h80);
        chk(result.status, 8'h00);
    endtask : sc_int_ret
    task automatic sc_sub_lit;
        issue(OP_CALL, 8'h00, 1'b0, 8'h00, 15'h0101);
        issue(OP_CALL, 8'h00, 1'b0, 8'h00, 15'h7FFF);
        ret(OP_SUB_RET, 8'h00, 15'h7FFF);
        chk(result.intctl, 8'h80);
        ret(OP_LIT_RET, 8'hFF, 15'h0101);
        chk(result.w, 8'hFF);
        chk(result.status, 8'h00);
    endtask : sc_sub_lit
    task automatic sc_rot;
        issue(OP_ROT_LEFT, 8'h00, 1'b1, 8'hE6, 15'h0000);
        chk({result.fwr_en, result.fwr_data}, 16'h01CC);
        chk(result.status, 8'h01);
        issue(OP_ROT_LEFT, 8'h00, 1'b0, 8'h01, 15'h0000);
        chk({result.fwr_en, result.w}, 16'h0003);
        chk(result.status, 8'h00);
    endtask : sc_rot
    // ce low must freeze everything: a rotate held meanwhile is taken only once ce returns
    task automatic sc_freeze;
        @(negedge clk);
        ce = 1'b0;
        instr_valid = 1'b1;
        instr = '{OP_ROT_LEFT, 8'h00, 1'b1, 8'h80, 15'h0000};
        repeat (2) @(negedge clk);
        chk({result.fwr_en, result.status}, 16'h0000);
        chk(result.w, 8'h03);
        ce = 1'b1;
        @(negedge clk);
        instr_valid = 1'b0;
        chk({result.fwr_en, result.fwr_data}, 16'h0100);
        chk(result.status, 8'h01);
    endtask : sc_freeze
    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        sc_int_ret();
        sc_sub_lit();
        sc_rot();
        sc_freeze();
        print_verdict();
    end
endmodule : testbench
